// ==== cfgp_pkg.sv ====
// Constants and types shared by the configuration port pin controller
package cfgp_pkg;

  // Clock rate and derived timing counts
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLEAR_TIME_NS = 1000;
  localparam int CLEAR_CYCLES = (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_NS = 200;
  localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_TIME_NS = 500;
  localparam int STARTUP_CYCLES = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Default length of a configuration image in bits
  localparam int CFG_BITS_DEFAULT = 1024;

  // Mode pin encodings
  localparam logic [1:0] MODE_SLAVE = 2'h0;
  localparam logic [1:0] MODE_MASTER = 2'h1;

  // Flash read command: opcode then a zero start address
  localparam logic [7:0] FLASH_READ_CMD = 8'h03;
  localparam int CMD_BITS = 32;

  // Test access port instruction register
  localparam int IR_W = 8;
  localparam logic [7:0] IR_CAPTURE = 8'h01;
  localparam logic [7:0] IR_BYPASS = 8'hff;
  localparam logic [7:0] IR_CFG_LOAD = 8'h3a;

  // Configuration ports that can take the lock
  typedef enum logic [1:0] {PORT_SLAVE, PORT_MASTER, PORT_JTAG} cfgp_port_type;

  // Main sequencer states
  typedef enum logic [2:0] {
    ST_CLEAR, ST_WAIT_INIT, ST_SELECT, ST_SLAVE, ST_MASTER, ST_JTAG, ST_STARTUP, ST_USER
  } cfgp_state_type;

  // Boundary-scan controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR,
    TAP_UP_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UP_IR
  } cfgp_tap_type;

  // Inputs crossing into the system clock domain
  typedef struct packed {
    logic [1:0] mode;
    logic init;
    logic done;
    logic program_n;
    logic toe_n;
    logic sclk;
    logic ssel_n;
    logic spi_a;
    logic spi_b;
    logic jtag_sel;
    logic jtag_fin;
  } cfgp_pins_type;

  // System clock domain state
  typedef struct packed {
    cfgp_state_type st;
    cfgp_pins_type s1;
    cfgp_pins_type s2;
    logic init_prev;
    logic sclk_prev;
    logic [1:0] mode;
    logic locked;
    cfgp_port_type port;
    logic [31:0] cnt;
    logic [7:0] div;
    logic [31:0] sr;
    logic [7:0] byt;
    logic bval;
    logic init_oe;
    logic done_oe;
    logic sclk_out;
    logic sclk_oe;
    logic a_out;
    logic a_oe;
    logic b_oe;
    logic fsel_n;
    logic user_en;
  } cfgp_sys_type;

  // Test clock domain state
  typedef struct packed {
    cfgp_tap_type tap;
    logic [7:0] ir;
    logic [7:0] irsr;
    logic byp;
    logic sel;
    logic fin;
    logic [31:0] dcnt;
  } cfgp_jtag_type;

endpackage

// ==== cfgp_port_ctrl.sv ====
// Configuration port pin controller: mode latch, status pins, SPI ports and test access port
// Functional notes
// - Mode pins are latched on the ready pin's rising edge and pick the mode.
// - Request input low restarts the configuration sequence.
// - Ready pin, open drain, signals readiness to accept configuration data.
// - Done pin, open drain, shows configuration finished and startup running.
// - First selected port is locked; others refused until power-up.
// - Test port instruction selects the test port for configuration data.
// - Standard boundary-scan state machine on mode select, test clock, data in/out.
// - Tristate input low forces all user I/O to high impedance.
// - SPI data A input in slave, output in master; B the opposite.
// - In master SPI mode the flash select output addresses the flash.
// - Configuration clock times transfers; output when master, input when slave.
`timescale 1ns/1ns
module cfgp_port_ctrl #(
  parameter int CFG_BITS = cfgp_pkg::CFG_BITS_DEFAULT
) (
  // Clocks and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic tck_i,
  // Mode pins and request
  input wire logic [1:0] cfg_mode_pins_i,
  input wire logic program_request_n_i,
  // Open-drain status pins
  input wire logic init_ready_n_i,
  output logic init_ready_n_o,
  output logic init_ready_n_oe_o,
  input wire logic done_i,
  output logic done_o,
  output logic done_oe_o,
  // Configuration clock and SPI pins
  input wire logic cfg_serial_clock_i,
  output logic cfg_serial_clock_o,
  output logic cfg_serial_clock_oe_o,
  input wire logic spi_data_a_i,
  output logic spi_data_a_o,
  output logic spi_data_a_oe_o,
  input wire logic spi_data_b_i,
  output logic spi_data_b_o,
  output logic spi_data_b_oe_o,
  output logic flash_select_n_o,
  input wire logic slave_select_n_i,
  // Test access port
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  // User I/O control and status
  input wire logic output_tristate_n_i,
  output logic user_io_enable_o,
  output logic [1:0] cfg_mode_o,
  output logic [1:0] cfg_port_o,
  output logic port_locked_o,
  output logic [7:0] cfg_byte_o,
  output logic cfg_byte_valid_o
);

  cfgp_pkg::cfgp_sys_type r, next_r;
  cfgp_pkg::cfgp_pins_type pins_raw;
  cfgp_pkg::cfgp_jtag_type t, next_t;
  logic rst_t1, rst_t2;
  logic tdo_q, tdo_en_q;
  logic init_rise, sclk_rise, last_bit;

  // Raw inputs gathered for the two-stage synchroniser
  assign pins_raw = '{mode: cfg_mode_pins_i, init: init_ready_n_i, done: done_i,
                      program_n: program_request_n_i, toe_n: output_tristate_n_i,
                      sclk: cfg_serial_clock_i, ssel_n: slave_select_n_i, spi_a: spi_data_a_i,
                      spi_b: spi_data_b_i, jtag_sel: t.sel, jtag_fin: t.fin};

  // Edge detect on synchronised pins only
  assign init_rise = r.s2.init & ~r.init_prev;
  assign sclk_rise = r.s2.sclk & ~r.sclk_prev;
  assign last_bit = r.cnt == 32'(CFG_BITS - 1);

  // Main sequencer
  always_comb begin
    next_r = r;
    next_r.s1 = pins_raw;
    next_r.s2 = r.s1;
    next_r.init_prev = r.s2.init;
    next_r.sclk_prev = r.s2.sclk;
    next_r.bval = 1'b0;
    case (r.st)
      cfgp_pkg::ST_CLEAR: begin
        next_r.cnt = r.cnt + 32'h1;
        if (r.cnt >= 32'(cfgp_pkg::CLEAR_CYCLES - 1)) begin
          next_r.st = cfgp_pkg::ST_WAIT_INIT;
        end
      end
      cfgp_pkg::ST_WAIT_INIT: begin
        if (init_rise) begin
          next_r.mode = r.s2.mode;
          next_r.st = cfgp_pkg::ST_SELECT;
        end
      end
      cfgp_pkg::ST_SELECT: begin
        next_r.cnt = 32'h0;
        // Port choice; a port other than the locked one is refused
        if (r.s2.jtag_sel && (!r.locked || r.port == cfgp_pkg::PORT_JTAG)) begin
          next_r.locked = 1'b1;
          next_r.port = cfgp_pkg::PORT_JTAG;
          next_r.st = cfgp_pkg::ST_JTAG;
        end else if (r.mode == cfgp_pkg::MODE_SLAVE && (!r.locked || r.port == cfgp_pkg::PORT_SLAVE)) begin
          next_r.locked = 1'b1;
          next_r.port = cfgp_pkg::PORT_SLAVE;
          next_r.st = cfgp_pkg::ST_SLAVE;
        end else if (r.mode == cfgp_pkg::MODE_MASTER && (!r.locked || r.port == cfgp_pkg::PORT_MASTER)) begin
          next_r.locked = 1'b1;
          next_r.port = cfgp_pkg::PORT_MASTER;
          next_r.st = cfgp_pkg::ST_MASTER;
          next_r.sr = {cfgp_pkg::FLASH_READ_CMD, 24'h0};
          next_r.div = 8'h0;
          next_r.sclk_out = 1'b0;
        end
      end
      cfgp_pkg::ST_SLAVE: begin
        // Host-driven clock and select, data in on A
        if (!r.s2.ssel_n && sclk_rise) begin
          next_r.byt = {r.byt[6:0], r.s2.spi_a};
          next_r.bval = r.cnt[2:0] == 3'h7;
          next_r.cnt = r.cnt + 32'h1;
          if (last_bit) begin
            next_r.st = cfgp_pkg::ST_STARTUP;
            next_r.cnt = 32'h0;
          end
        end
      end
      cfgp_pkg::ST_MASTER: begin
        // Divided clock out; command shifts on A, image arrives on B
        next_r.div = r.div + 8'h1;
        if (r.div == 8'(cfgp_pkg::SCLK_HALF_CYCLES - 1)) begin
          next_r.div = 8'h0;
          next_r.sclk_out = ~r.sclk_out;
          if (!r.sclk_out) begin
            next_r.cnt = r.cnt + 32'h1;
          end else begin
            next_r.sr = {r.sr[30:0], 1'b0};
            // Synced B lags two cycles, so at the fall it shows the bit held at the last rise
            if (r.cnt > 32'(cfgp_pkg::CMD_BITS)) begin
              next_r.byt = {r.byt[6:0], r.s2.spi_b};
              next_r.bval = r.cnt[2:0] == 3'h0;
            end
            if (r.cnt == 32'(cfgp_pkg::CMD_BITS + CFG_BITS)) begin
              next_r.st = cfgp_pkg::ST_STARTUP;
              next_r.cnt = 32'h0;
              next_r.sclk_out = 1'b0;
            end
          end
        end
      end
      cfgp_pkg::ST_JTAG: begin
        if (r.s2.jtag_fin) begin
          next_r.st = cfgp_pkg::ST_STARTUP;
          next_r.cnt = 32'h0;
        end
      end
      cfgp_pkg::ST_STARTUP: begin
        // Done released; wait for the wired pin to rise and the startup time
        if (r.s2.done) begin
          next_r.cnt = r.cnt + 32'h1;
        end
        if (r.s2.done && r.cnt >= 32'(cfgp_pkg::STARTUP_CYCLES - 1)) begin
          next_r.st = cfgp_pkg::ST_USER;
        end
      end
      cfgp_pkg::ST_USER: begin
        next_r.cnt = 32'h0;
      end
      default: begin
        next_r.st = cfgp_pkg::ST_CLEAR;
      end
    endcase
    // Request low restarts; the port lock survives
    if (!r.s2.program_n) begin
      next_r.st = cfgp_pkg::ST_CLEAR;
      next_r.cnt = 32'h0;
      next_r.sclk_out = 1'b0;
    end
    // Pin drivers follow the next state
    next_r.init_oe = next_r.st == cfgp_pkg::ST_CLEAR;
    next_r.done_oe = !(next_r.st == cfgp_pkg::ST_STARTUP || next_r.st == cfgp_pkg::ST_USER);
    next_r.sclk_oe = next_r.st == cfgp_pkg::ST_MASTER;
    next_r.a_oe = next_r.st == cfgp_pkg::ST_MASTER;
    next_r.b_oe = next_r.st == cfgp_pkg::ST_SLAVE;
    next_r.a_out = next_r.sr[31];
    next_r.fsel_n = next_r.st != cfgp_pkg::ST_MASTER;
    next_r.user_en = next_r.st == cfgp_pkg::ST_USER && r.s2.toe_n;
  end

  // System domain register
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      r <= '0;
      r.st <= cfgp_pkg::ST_CLEAR;
      r.s1.program_n <= 1'b1;
      r.s2.program_n <= 1'b1;
      r.init_oe <= 1'b1;
      r.done_oe <= 1'b1;
      r.fsel_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Test clock domain reset synchroniser
  always_ff @(posedge tck_i) begin
    rst_t1 <= nrst_i;
    rst_t2 <= rst_t1;
  end

  // Boundary-scan controller and configuration instruction
  always_comb begin
    next_t = t;
    case (t.tap)
      cfgp_pkg::TAP_RESET: next_t.tap = tms_i ? cfgp_pkg::TAP_RESET : cfgp_pkg::TAP_IDLE;
      cfgp_pkg::TAP_IDLE: next_t.tap = tms_i ? cfgp_pkg::TAP_SEL_DR : cfgp_pkg::TAP_IDLE;
      cfgp_pkg::TAP_SEL_DR: next_t.tap = tms_i ? cfgp_pkg::TAP_SEL_IR : cfgp_pkg::TAP_CAP_DR;
      cfgp_pkg::TAP_CAP_DR: next_t.tap = tms_i ? cfgp_pkg::TAP_EX1_DR : cfgp_pkg::TAP_SH_DR;
      cfgp_pkg::TAP_SH_DR: next_t.tap = tms_i ? cfgp_pkg::TAP_EX1_DR : cfgp_pkg::TAP_SH_DR;
      cfgp_pkg::TAP_EX1_DR: next_t.tap = tms_i ? cfgp_pkg::TAP_UP_DR : cfgp_pkg::TAP_PA_DR;
      cfgp_pkg::TAP_PA_DR: next_t.tap = tms_i ? cfgp_pkg::TAP_EX2_DR : cfgp_pkg::TAP_PA_DR;
      cfgp_pkg::TAP_EX2_DR: next_t.tap = tms_i ? cfgp_pkg::TAP_UP_DR : cfgp_pkg::TAP_SH_DR;
      cfgp_pkg::TAP_UP_DR: next_t.tap = tms_i ? cfgp_pkg::TAP_SEL_DR : cfgp_pkg::TAP_IDLE;
      cfgp_pkg::TAP_SEL_IR: next_t.tap = tms_i ? cfgp_pkg::TAP_RESET : cfgp_pkg::TAP_CAP_IR;
      cfgp_pkg::TAP_CAP_IR: next_t.tap = tms_i ? cfgp_pkg::TAP_EX1_IR : cfgp_pkg::TAP_SH_IR;
      cfgp_pkg::TAP_SH_IR: next_t.tap = tms_i ? cfgp_pkg::TAP_EX1_IR : cfgp_pkg::TAP_SH_IR;
      cfgp_pkg::TAP_EX1_IR: next_t.tap = tms_i ? cfgp_pkg::TAP_UP_IR : cfgp_pkg::TAP_PA_IR;
      cfgp_pkg::TAP_PA_IR: next_t.tap = tms_i ? cfgp_pkg::TAP_EX2_IR : cfgp_pkg::TAP_PA_IR;
      cfgp_pkg::TAP_EX2_IR: next_t.tap = tms_i ? cfgp_pkg::TAP_UP_IR : cfgp_pkg::TAP_SH_IR;
      cfgp_pkg::TAP_UP_IR: next_t.tap = tms_i ? cfgp_pkg::TAP_SEL_DR : cfgp_pkg::TAP_IDLE;
      default: next_t.tap = cfgp_pkg::TAP_RESET;
    endcase
    case (t.tap)
      cfgp_pkg::TAP_RESET: next_t.ir = cfgp_pkg::IR_BYPASS;
      cfgp_pkg::TAP_CAP_IR: next_t.irsr = cfgp_pkg::IR_CAPTURE;
      cfgp_pkg::TAP_SH_IR: next_t.irsr = {tdi_i, t.irsr[7:1]};
      cfgp_pkg::TAP_UP_IR: begin
        next_t.ir = t.irsr;
        if (t.irsr == cfgp_pkg::IR_CFG_LOAD) begin
          next_t.sel = 1'b1;
        end
      end
      cfgp_pkg::TAP_CAP_DR: next_t.byp = 1'b0;
      cfgp_pkg::TAP_SH_DR: begin
        next_t.byp = tdi_i;
        // Image bits counted while the load instruction is current
        if (t.ir == cfgp_pkg::IR_CFG_LOAD && !t.fin) begin
          next_t.dcnt = t.dcnt + 32'h1;
          next_t.fin = t.dcnt == 32'(CFG_BITS - 1);
        end
      end
      default: next_t.byp = t.byp;
    endcase
  end

  // Test clock domain register
  always_ff @(posedge tck_i) begin
    if (!rst_t2) begin
      t <= '0;
      t.ir <= cfgp_pkg::IR_BYPASS;
    end else begin
      t <= next_t;
    end
  end

  // Test data out changes on the falling test clock
  always_ff @(negedge tck_i) begin
    if (!rst_t2) begin
      tdo_q <= 1'b0;
      tdo_en_q <= 1'b0;
    end else begin
      tdo_q <= (t.tap == cfgp_pkg::TAP_SH_IR) ? t.irsr[0] : t.byp;
      tdo_en_q <= t.tap == cfgp_pkg::TAP_SH_IR || t.tap == cfgp_pkg::TAP_SH_DR;
    end
  end

  // Output pins
  assign init_ready_n_o = 1'b0;
  assign init_ready_n_oe_o = r.init_oe;
  assign done_o = 1'b0;
  assign done_oe_o = r.done_oe;
  assign cfg_serial_clock_o = r.sclk_out;
  assign cfg_serial_clock_oe_o = r.sclk_oe;
  assign spi_data_a_o = r.a_out;
  assign spi_data_a_oe_o = r.a_oe;
  assign spi_data_b_o = 1'b0;
  assign spi_data_b_oe_o = r.b_oe;
  assign flash_select_n_o = r.fsel_n;
  assign tdo_o = tdo_q;
  assign tdo_oe_o = tdo_en_q;
  assign user_io_enable_o = r.user_en;
  assign cfg_mode_o = r.mode;
  assign cfg_port_o = r.port;
  assign port_locked_o = r.locked;
  assign cfg_byte_o = r.byt;
  assign cfg_byte_valid_o = r.bval;

  // Checks
  chk_mode_latch: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (r.st == cfgp_pkg::ST_WAIT_INIT && init_rise && r.s2.program_n) |=> (r.mode == $past(r.s2.mode)))
    else $error("mode not latched on ready rise");
  chk_program_restart: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !r.s2.program_n |=> (r.st == cfgp_pkg::ST_CLEAR && r.init_oe))
    else $error("request low did not restart");
  chk_init_release: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (r.st == cfgp_pkg::ST_CLEAR && r.s2.program_n)[*8] |=> ##[0:4] !r.init_oe)
    else $error("ready pin held too long");
  chk_done_pin: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (r.st == cfgp_pkg::ST_JTAG && r.s2.jtag_fin && r.s2.program_n) |=> (!r.done_oe && r.st == cfgp_pkg::ST_STARTUP))
    else $error("done pin not released at finish");
  chk_port_lock: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(r.locked) |-> (r.locked && r.port == $past(r.port)))
    else $error("locked port changed");
  chk_jtag_enter: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (r.st == cfgp_pkg::ST_SELECT && r.s2.jtag_sel && !r.locked && r.s2.program_n) |=> (r.st == cfgp_pkg::ST_JTAG))
    else $error("test port not taken");
  chk_tap_reset: assert property (@(posedge tck_i) disable iff (!rst_t2)
    tms_i[*5] |=> (t.tap == cfgp_pkg::TAP_RESET))
    else $error("tap not in reset after five mode-select highs");
  chk_user_tristate: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !r.s2.toe_n |=> !user_io_enable_o)
    else $error("user io enabled while tristate low");
  chk_spi_dirs: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !(spi_data_a_oe_o && spi_data_b_oe_o) && (spi_data_b_oe_o == (r.st == cfgp_pkg::ST_SLAVE)))
    else $error("spi data directions wrong");
  chk_flash_select: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(r.st == cfgp_pkg::ST_MASTER) |-> $fell(flash_select_n_o) && cfg_serial_clock_oe_o)
    else $error("flash not selected in master mode");

endmodule // cfgp_port_ctrl

// ==== cfgp_far_end.sv ====
// Far-side model: config host, SPI flash and pull-ups on shared pins
`timescale 1ns/1ns
module cfgp_far_end (
  // Host clock
  input wire logic clk_i,
  // Device pin drivers and flash image
  input wire logic init_oe_i,
  input wire logic done_oe_i,
  input wire logic sclk_i,
  input wire logic sclk_oe_i,
  input wire logic a_i,
  input wire logic a_oe_i,
  input wire logic b_i,
  input wire logic b_oe_i,
  input wire logic fsel_n_i,
  input wire logic [15:0] image_i,
  // Wired pin levels and flash view
  output logic init_pin_o,
  output logic done_pin_o,
  output logic sclk_pin_o,
  output logic a_pin_o,
  output logic b_pin_o,
  output logic ssel_n_o,
  output logic [31:0] cmd_o
);
  logic host_sclk = 1'b0;
  logic host_a = 1'b0;
  logic fl_bit = 1'b0;
  logic [5:0] rises = 6'h0;
  initial ssel_n_o = 1'b1;
  // Pull-ups on open-drain pins, else whoever drives
  assign init_pin_o = init_oe_i ? 1'b0 : 1'b1;
  assign done_pin_o = done_oe_i ? 1'b0 : 1'b1;
  assign sclk_pin_o = sclk_oe_i ? sclk_i : host_sclk;
  assign a_pin_o = a_oe_i ? a_i : host_a;
  // Released flash output shows the inverse of its last bit
  assign b_pin_o = b_oe_i ? b_i : (fsel_n_i ? ~fl_bit : fl_bit);
  // Flash gathers the read command on rising clock edges
  always @(posedge sclk_pin_o or posedge fsel_n_i) begin
    if (fsel_n_i) begin
      rises <= 6'h0;
    end else begin
      if (rises < 6'h20) cmd_o <= {cmd_o[30:0], a_pin_o};
      rises <= rises + 6'h1;
    end
  end
  // Flash shifts the image out after falling edges
  always @(negedge sclk_pin_o) begin
    if (!fsel_n_i && rises >= 6'h20 && rises < 6'h30) fl_bit <= image_i[6'h2f - rises];
  end
  // Host sends an image MSB first with select low; slow clock idles low
  task automatic host_send(input logic [15:0] d);
    ssel_n_o <= 1'b0;
    for (int k = 15; k >= 0; k--) begin
      repeat (4) @(posedge clk_i);
      host_a <= d[k];
      repeat (4) @(posedge clk_i);
      host_sclk <= 1'b1;
      repeat (4) @(posedge clk_i);
      host_sclk <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    ssel_n_o <= 1'b1;
    host_a <= ~d[0];
  endtask
endmodule // cfgp_far_end

// ==== test_cfgp_port_ctrl.sv ====
// Self-checking bench for the configuration port pin controller
`timescale 1ns/1ns
module test_cfgp_port_ctrl;
  localparam logic [9:0] TO_SHIFT_IR = 10'h0df;
  localparam logic [4:0] TO_SHIFT_DR = 5'h05;
  logic clk_i, nrst_i, tck_i, program_request_n_i, output_tristate_n_i, tms_i, tdi_i;
  logic ready_pin, done_pin, sclk_pin, a_pin, b_pin, ssel_n, init_oe, done_oe, sclk_o, sclk_oe;
  logic a_o, a_oe, b_o, b_oe, fsel_n, tdo_o, tdo_oe, user_en, byte_valid, locked, bit_s;
  logic [1:0] cfg_mode_pins_i, mode_o, port_o;
  logic [7:0] byte_o, cap;
  logic [15:0] image;
  logic [31:0] cmd_seen;
  logic [7:0] exp_q[$];
  int num_errors = 0;
  int checked = 0;
  int n;

  cfgp_port_ctrl #(.CFG_BITS(16)) cfgp_port_ctrl_inst (
    .clk_i(clk_i), .nrst_i(nrst_i), .tck_i(tck_i), .cfg_mode_pins_i(cfg_mode_pins_i),
    .program_request_n_i(program_request_n_i), .init_ready_n_i(ready_pin), .init_ready_n_o(),
    .init_ready_n_oe_o(init_oe), .done_i(done_pin), .done_o(), .done_oe_o(done_oe),
    .cfg_serial_clock_i(sclk_pin), .cfg_serial_clock_o(sclk_o), .cfg_serial_clock_oe_o(sclk_oe),
    .spi_data_a_i(a_pin), .spi_data_a_o(a_o), .spi_data_a_oe_o(a_oe), .spi_data_b_i(b_pin),
    .spi_data_b_o(b_o), .spi_data_b_oe_o(b_oe), .flash_select_n_o(fsel_n), .slave_select_n_i(ssel_n),
    .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe),
    .output_tristate_n_i(output_tristate_n_i), .user_io_enable_o(user_en), .cfg_mode_o(mode_o),
    .cfg_port_o(port_o), .port_locked_o(locked), .cfg_byte_o(byte_o), .cfg_byte_valid_o(byte_valid));

  cfgp_far_end cfgp_far_end_inst (
    .clk_i(clk_i), .init_oe_i(init_oe), .done_oe_i(done_oe), .sclk_i(sclk_o), .sclk_oe_i(sclk_oe),
    .a_i(a_o), .a_oe_i(a_oe), .b_i(b_o), .b_oe_i(b_oe), .fsel_n_i(fsel_n), .image_i(image),
    .init_pin_o(ready_pin), .done_pin_o(done_pin), .sclk_pin_o(sclk_pin), .a_pin_o(a_pin),
    .b_pin_o(b_pin), .ssel_n_o(ssel_n), .cmd_o(cmd_seen));

  // System clock, 100 ns
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Test clock runs free, 30 ns, offset in phase
  initial begin
    tck_i = 1'b0;
    #7;
    forever #15 tck_i = ~tck_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Counts: %0d mismatches, %0d comparisons", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  function automatic logic hit(input int sel);
    case (sel)
      0: return init_oe === 1'b0;
      1: return done_oe === 1'b0;
      2: return user_en === 1'b1;
      default: return fsel_n === 1'b0;
    endcase
  endfunction

  // Expected byte k of an image, MSB first
  function automatic logic [7:0] byte_of(input logic [15:0] d, input int k);
    return d[15 - 8 * k -: 8];
  endfunction

  // Bounded wait, sampled on the falling clock edge
  task automatic wait_for(input int sel);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (n < 3000 && !hit(sel));
    if (n == 3000) begin
      num_errors++;
      $display("mismatch at %0t: wait %0d ran out", $time, sel);
      end_sim();
    end
  endtask

  task automatic do_reset(input logic [1:0] mode);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    cfg_mode_pins_i <= mode;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
  endtask

  // One test clock step: drive on falling, sample on rising
  task automatic tap(input logic ms, input logic di);
    @(negedge tck_i);
    tms_i <= ms;
    tdi_i <= di;
    @(posedge tck_i);
    bit_s = tdo_o;
  endtask

  // Every delivered byte must be the next one expected
  always @(posedge clk_i) begin
    if (nrst_i && byte_valid === 1'b1) check(byte_o, exp_q.size() ? exp_q.pop_front() : 8'hxx);
  end

  initial begin
    nrst_i = 1'b0;
    program_request_n_i = 1'b1;
    output_tristate_n_i = 1'b1;
    cfg_mode_pins_i = cfgp_pkg::MODE_SLAVE;
    tms_i = 1'b1;
    tdi_i = 1'b0;
    image = 16'h00ff;
    void'($urandom(78));
    // Reset levels, then ready pin released after the clear time
    do_reset(cfgp_pkg::MODE_SLAVE);
    check({init_oe, done_oe, fsel_n, user_en, locked}, 5'h1c);
    wait_for(0);
    check(n inside {[cfgp_pkg::CLEAR_CYCLES - 1 : cfgp_pkg::CLEAR_CYCLES + 2]}, 1);
    // Slave SPI: pin directions, bytes, done, startup
    repeat (8) @(negedge clk_i);
    check(mode_o, cfgp_pkg::MODE_SLAVE);
    check({a_oe, b_oe, sclk_oe, fsel_n}, 4'h5);
    exp_q.push_back(byte_of(image, 0));
    exp_q.push_back(byte_of(image, 1));
    @(posedge clk_i);
    cfgp_far_end_inst.host_send(image);
    wait_for(1);
    check({port_o, locked}, {cfgp_pkg::PORT_SLAVE, 1'b1});
    wait_for(2);
    check(exp_q.size(), 0);
    @(posedge clk_i);
    output_tristate_n_i <= 1'b0;
    repeat (5) @(negedge clk_i);
    check(user_en, 0);
    // Restart with master mode pins: mode latched, port stays locked
    @(posedge clk_i);
    output_tristate_n_i <= 1'b1;
    cfg_mode_pins_i <= cfgp_pkg::MODE_MASTER;
    program_request_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    program_request_n_i <= 1'b1;
    repeat (3) @(negedge clk_i);
    check(init_oe, 1);
    wait_for(0);
    repeat (60) @(negedge clk_i);
    check(mode_o, cfgp_pkg::MODE_MASTER);
    check({port_o, fsel_n, done_oe}, {cfgp_pkg::PORT_SLAVE, 2'h3});
    // Power-up clears the lock; master SPI reads a random image
    image = 16'($urandom);
    do_reset(cfgp_pkg::MODE_MASTER);
    exp_q.push_back(byte_of(image, 0));
    exp_q.push_back(byte_of(image, 1));
    wait_for(3);
    check({sclk_oe, a_oe, b_oe}, 3'h6);
    wait_for(1);
    check(cmd_seen, {cfgp_pkg::FLASH_READ_CMD, 24'h0});
    check({fsel_n, port_o}, {1'b1, cfgp_pkg::PORT_MASTER});
    wait_for(2);
    check(exp_q.size(), 0);
    // Test port: capture value, config instruction, data shift
    do_reset(2'h2);
    wait_for(0);
    for (int k = 0; k < 10; k++) tap(TO_SHIFT_IR[k], 1'b0);
    for (int k = 0; k < 8; k++) begin
      tap(k == 7, cfgp_pkg::IR_CFG_LOAD[k]);
      cap[k] = bit_s;
    end
    check(cap, cfgp_pkg::IR_CAPTURE);
    for (int k = 0; k < 5; k++) tap(TO_SHIFT_DR[k], 1'b0);
    for (int k = 0; k < 16; k++) tap(k == 15, image[15 - k]);
    check(tdo_oe, 1);
    tap(1'b1, 1'b0);
    tap(1'b0, 1'b0);
    wait_for(1);
    check({port_o, locked}, {cfgp_pkg::PORT_JTAG, 1'b1});
    wait_for(2);
    end_sim();
  end
endmodule // test_cfgp_port_ctrl
